// ===== design/hia_top.sv
`timescale 1ns/1ps
// Overview of operation
// - Any source event sets its pending flag; enabled flags pull the alert low.
// - Alert stays low until every enabled pending flag is cleared.
// - Reading a clearing status register returns its flags and clears them.
// - Writing zero to an enable bit masks that source from the alert.
// - Enabled clock events also set low-power status, which blocks their clearing.
// - Peek registers return pending flags without clearing any of them.
// - Clock alarm sets status 0 bit 4, gated by enable 0 bit 4.
// - Oscillator failure sets status 0 bit 3, gated by enable 0 bit 3.
// - Port match sets status 0 bit 0, gated by enable 0 bit 0.
// - Initialization done sets status 1 bit 4, gated by enable 1 bit 4.
// - Timer 1 rollover sets status 1 bit 3, gated by enable 1 bit 3.
// - Timer 0 rollover sets status 1 bit 2, gated by enable 1 bit 2.
// - Status 0 sits at 0x43, resets to zero, unused bits read zero.
module hia_top (
   input  wire logic                  i_ref_clk,
   input  wire logic                  i_rst,
   input  wire hia_pkg::hia_events_t  i_events,
   input  wire hia_pkg::hia_reg_req_t i_reg,
   output logic [7:0]                 o_reg_rdata,
   output logic                       o_reg_rvalid,
   output logic                       o_alert_n
);

   ////////////////////////////////////////////////////////////////////////////////
   // Decode

   wire logic       rd_clr0;
   wire logic       rd_clr1;
   wire logic       rd_peek0;
   wire logic       rd_peek1;
   wire logic       wr_en0;
   wire logic       wr_en1;
   wire logic       wr_lpst;
   wire logic [7:0] stat0;
   wire logic [7:0] stat1;
   wire logic [7:0] lpst;
   wire logic [7:0] set0;
   wire logic [7:0] set1;
   wire logic [7:0] set_lp;
   wire logic [7:0] clr0;
   wire logic [7:0] clr1;
   wire logic [7:0] clr_lp;
   wire logic [7:0] lp_hold;
   wire logic [7:0] pend_en;
   wire logic [7:0] next_rdata;
   wire logic       next_alert_n;
   logic      [7:0] irq_enable0;
   logic      [7:0] irq_enable1;

   assign rd_clr0  = i_reg.rd && (i_reg.addr == hia_pkg::OFF_CLR0);
   assign rd_clr1  = i_reg.rd && (i_reg.addr == hia_pkg::OFF_CLR1);
   assign rd_peek0 = i_reg.rd && (i_reg.addr == hia_pkg::OFF_PEEK0);
   assign rd_peek1 = i_reg.rd && (i_reg.addr == hia_pkg::OFF_PEEK1);
   assign wr_en0   = i_reg.wr && (i_reg.addr == hia_pkg::OFF_EN0);
   assign wr_en1   = i_reg.wr && (i_reg.addr == hia_pkg::OFF_EN1);
   assign wr_lpst  = i_reg.wr && (i_reg.addr == hia_pkg::OFF_LPST);

   ////////////////////////////////////////////////////////////////////////////////
   // Event capture

   assign set0 = (8'(i_events.alarm)      << hia_pkg::BIT_ALARM)
               | (8'(i_events.osc_fail)   << hia_pkg::BIT_FAIL)
               | (8'(i_events.port_match) << hia_pkg::BIT_PMATCH);
   assign set1 = (8'(i_events.reset_done) << hia_pkg::BIT_RSTDONE)
               | (8'(i_events.tmr1)       << hia_pkg::BIT_TMR1)
               | (8'(i_events.tmr0)       << hia_pkg::BIT_TMR0);

   // Only enabled clock events reach the low-power status
   assign set_lp  = set0 & irq_enable0 & hia_pkg::MASK_LP;
   // Host clears a low-power bit by writing zero to it
   assign clr_lp  = wr_lpst ? ~i_reg.wdata : 8'h00;
   assign lp_hold = lpst & hia_pkg::MASK_LP;

   // Only flags returned by the read are cleared; sets win in the cell
   assign clr0 = rd_clr0 ? (stat0 & ~lp_hold) : 8'h00;
   assign clr1 = rd_clr1 ? stat1 : 8'h00;

   hia_flag_reg #(
      .MASK  (hia_pkg::MASK0),
      .RST_V (hia_pkg::RST_STAT0)
   ) u_stat0 (
      .i_ref_clk (i_ref_clk),
      .i_rst     (i_rst),
      .i_set     (set0),
      .i_clr     (clr0),
      .o_q       (stat0)
   );

   hia_flag_reg #(
      .MASK  (hia_pkg::MASK1),
      .RST_V (hia_pkg::RST_STAT1)
   ) u_stat1 (
      .i_ref_clk (i_ref_clk),
      .i_rst     (i_rst),
      .i_set     (set1),
      .i_clr     (clr1),
      .o_q       (stat1)
   );

   hia_flag_reg #(
      .MASK  (hia_pkg::MASK_LP),
      .RST_V (hia_pkg::RST_LPST)
   ) u_lpst (
      .i_ref_clk (i_ref_clk),
      .i_rst     (i_rst),
      .i_set     (set_lp),
      .i_clr     (clr_lp),
      .o_q       (lpst)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Enables

   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         irq_enable0 <= hia_pkg::RST_EN0;
         irq_enable1 <= hia_pkg::RST_EN1;
      end else begin
         if (wr_en0) begin
            irq_enable0 <= i_reg.wdata;
         end
         if (wr_en1) begin
            irq_enable1 <= i_reg.wdata;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Alert pin and read data

   assign pend_en = (stat0 & irq_enable0 & hia_pkg::MASK0)
                  | (stat1 & irq_enable1 & hia_pkg::MASK1);
   assign next_alert_n = ~|pend_en;

   // Peeks share the flag sources but never drive a clear
   assign next_rdata =
        (i_reg.addr == hia_pkg::OFF_CLR0)  ? stat0
      : (i_reg.addr == hia_pkg::OFF_PEEK0) ? stat0
      : (i_reg.addr == hia_pkg::OFF_CLR1)  ? stat1
      : (i_reg.addr == hia_pkg::OFF_PEEK1) ? stat1
      : (i_reg.addr == hia_pkg::OFF_LPST)  ? lpst
      : (i_reg.addr == hia_pkg::OFF_EN0)   ? (irq_enable0 | hia_pkg::EN0_ONES)
      : (i_reg.addr == hia_pkg::OFF_EN1)   ? irq_enable1
      : 8'h00;

   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         o_reg_rdata  <= hia_pkg::RST_RDATA;
         o_reg_rvalid <= 1'b0;
         o_alert_n    <= 1'b1;
      end else begin
         o_reg_rdata  <= i_reg.rd ? next_rdata : o_reg_rdata;
         o_reg_rvalid <= i_reg.rd;
         o_alert_n    <= next_alert_n;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Checks

   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (i_rst);

   sequence s_clr0_read;
      rd_clr0 && (set0 == 8'h00) && (lp_hold == 8'h00);
   endsequence

   sequence s_flags0_gone;
      ##1 (stat0 == 8'h00) ##1 (1'b1);
   endsequence

   alarm_sets_a: assert property (i_events.alarm |=> stat0[4])
      else $error("alarm event did not set status 0 bit 4");
   fail_sets_a: assert property (i_events.osc_fail |=> stat0[3])
      else $error("oscillator failure did not set status 0 bit 3");
   pmatch_sets_a: assert property (i_events.port_match |=> stat0[0])
      else $error("port match did not set status 0 bit 0");
   rstdone_sets_a: assert property (i_events.reset_done |=> stat1[4])
      else $error("reset complete did not set status 1 bit 4");
   tmr1_sets_a: assert property (i_events.tmr1 |=> stat1[3])
      else $error("timer 1 event did not set status 1 bit 3");
   tmr0_sets_a: assert property (i_events.tmr0 |=> stat1[2])
      else $error("timer 0 event did not set status 1 bit 2");
   alert_asserts_a: assert property ((|pend_en) |=> !o_alert_n)
      else $error("enabled pending flag without alert low");
   alert_holds_a: assert property (!o_alert_n && (|pend_en) |=> !o_alert_n)
      else $error("alert released while enabled flag pending");
   mask_release_a: assert property ((pend_en == 8'h00) |=> o_alert_n)
      else $error("alert low with no enabled pending flag");
   clear_read_a: assert property (s_clr0_read |-> s_flags0_gone)
      else $error("clearing read of status 0 left flags set");
   read_returns_a: assert property (rd_clr0 |=> o_reg_rdata == $past(stat0))
      else $error("clearing read returned wrong value");
   lp_blocks_a: assert property (rd_clr0 && stat0[4] && lpst[4] |=> stat0[4])
      else $error("alarm flag cleared while low-power bit set");
   lp_capture_a: assert property (i_events.alarm && irq_enable0[4] |=> lpst[4])
      else $error("enabled alarm not recorded in low-power status");
   peek_keeps_a: assert property (rd_peek0 && !i_reg.wr |=> stat0 == $past(stat0 | set0))
      else $error("peek read changed status 0");
   race_keeps_a: assert property (rd_clr1 && i_events.tmr0 |=> stat1[2])
      else $error("event during clearing read was lost");
   reserved_zero_a: assert property ((stat0 & ~hia_pkg::MASK0) == 8'h00)
      else $error("unused status 0 bit set");

   race0_keeps_a: assert property (rd_clr0 && i_events.port_match |=> stat0[0])
      else $error("port match during clearing read was lost");
   peek1_keeps_a: assert property (rd_peek1 && !i_reg.wr |=> stat1 == $past(stat1 | set1))
      else $error("peek read changed status 1");
   peek_returns_a: assert property (rd_peek0 |=> o_reg_rdata == $past(stat0))
      else $error("peek read of status 0 returned wrong value");
   clear1_read_a: assert property (rd_clr1 && (set1 == 8'h00) |=> stat1 == 8'h00)
      else $error("clearing read of status 1 left flags set");
   read1_returns_a: assert property (rd_clr1 |=> o_reg_rdata == $past(stat1))
      else $error("clearing read of status 1 returned wrong value");
   fail_capture_a: assert property (i_events.osc_fail && irq_enable0[3] |=> lpst[3])
      else $error("enabled oscillator failure not recorded in low-power status");
   enable_write_a: assert property (wr_en0 |=> irq_enable0 == $past(i_reg.wdata))
      else $error("enable 0 write did not land");

endmodule : hia_top

// ===== design/hia_pkg.sv
package hia_pkg;

   localparam int          DATA_W      = 8;
   localparam int          ADDR_W      = 8;

   // Register offsets
   localparam logic [7:0]  OFF_EN0     = 8'h30;
   localparam logic [7:0]  OFF_EN1     = 8'h31;
   localparam logic [7:0]  OFF_PEEK0   = 8'h40;
   localparam logic [7:0]  OFF_PEEK1   = 8'h41;
   localparam logic [7:0]  OFF_LPST    = 8'h42;
   localparam logic [7:0]  OFF_CLR0    = 8'h43;
   localparam logic [7:0]  OFF_CLR1    = 8'h44;

   // Field positions, status and enable 0
   localparam int          BIT_ALARM   = 4;
   localparam int          BIT_FAIL    = 3;
   localparam int          BIT_PMATCH  = 0;
   // Field positions, status and enable 1
   localparam int          BIT_RSTDONE = 4;
   localparam int          BIT_TMR1    = 3;
   localparam int          BIT_TMR0    = 2;

   // Implemented bits of each register
   localparam logic [7:0]  MASK0       = 8'h19;
   localparam logic [7:0]  MASK1       = 8'h1C;
   localparam logic [7:0]  MASK_LP     = 8'h18;
   localparam logic [7:0]  MASK_EN     = 8'hFF;
   // Enable 0 upper bits always read as ones
   localparam logic [7:0]  EN0_ONES    = 8'hC0;

   // Values after reset
   localparam logic [7:0]  RST_STAT0   = 8'h00;
   localparam logic [7:0]  RST_STAT1   = 8'h04;
   localparam logic [7:0]  RST_LPST    = 8'h00;
   localparam logic [7:0]  RST_EN0     = 8'hF7;
   localparam logic [7:0]  RST_EN1     = 8'hFF;
   localparam logic [7:0]  RST_RDATA   = 8'h00;

   typedef struct packed {
      logic alarm;
      logic osc_fail;
      logic port_match;
      logic reset_done;
      logic tmr1;
      logic tmr0;
   } hia_events_t;

   typedef struct packed {
      logic [7:0] addr;
      logic       rd;
      logic       wr;
      logic [7:0] wdata;
   } hia_reg_req_t;

endpackage : hia_pkg

// ===== design/hia_flag_reg.sv
`timescale 1ns/1ps
// Sticky flag register: a set in the same cycle as a clear wins
module hia_flag_reg #(
   parameter logic [7:0] MASK  = 8'hFF,
   parameter logic [7:0] RST_V = 8'h00
) (
   input  wire logic       i_ref_clk,
   input  wire logic       i_rst,
   input  wire logic [7:0] i_set,
   input  wire logic [7:0] i_clr,
   output logic      [7:0] o_q
);

   wire logic [7:0] next_q;

   assign next_q = ((o_q & ~i_clr) | i_set) & MASK;

   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         o_q <= RST_V;
      end else begin
         o_q <= next_q;
      end
   end

endmodule : hia_flag_reg

// ===== verif/hia_host_model.sv
`timescale 1ns/1ps
module hia_host_model (
   input  wire logic              i_ref_clk,
   input  wire logic [7:0]        i_rdata,
   input  wire logic              i_rvalid,
   output hia_pkg::hia_reg_req_t  o_reg
);
   initial o_reg = '{addr: 8'hA5, rd: 1'b0, wr: 1'b0, wdata: 8'h5A};
   ////////////////////////////////////////////////////////////////////
   // One strobe cycle; idle bus shows inverted values, never stale ones
   task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] wd,
                       output logic [7:0] d, output logic v);
      @(negedge i_ref_clk);
      o_reg = '{addr: a, rd: !w, wr: w, wdata: wd};
      @(negedge i_ref_clk);
      d = i_rdata;
      v = i_rvalid;
      o_reg = '{addr: ~a, rd: 1'b0, wr: 1'b0, wdata: ~wd};
   endtask : xfer
endmodule : hia_host_model

// ===== verif/hia_top_tb.sv
`timescale 1ns/1ps
module hia_top_tb;
   logic                  i_ref_clk = 1'b0;
   logic                  i_rst     = 1'b1;
   hia_pkg::hia_events_t  ev        = '0;
   hia_pkg::hia_reg_req_t req;
   logic [7:0]            rdata;
   logic                  rvalid;
   logic                  alert_n;
   logic [7:0]            st0, st1, lp, en0, en1, d;
   logic                  v;
   int                    failures = 0;
   int                    checked  = 0;
   int                    cycles   = 0;
   logic [7:0]            addrs [8] = '{8'h30, 8'h31, 8'h40, 8'h41, 8'h42, 8'h43, 8'h44, 8'h55};

   always #12.5 i_ref_clk = ~i_ref_clk;

   hia_top i_hia_top (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_events(ev), .i_reg(req),
      .o_reg_rdata(rdata), .o_reg_rvalid(rvalid), .o_alert_n(alert_n));
   hia_host_model i_hia_host_model (.i_ref_clk(i_ref_clk), .i_rdata(rdata),
      .i_rvalid(rvalid), .o_reg(req));
   ////////////////////////////////////////////////////////////////////
   task automatic tally_and_finish;
      $display("checked %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : tally_and_finish

   task automatic chk(input string n, input logic [7:0] seen, input logic [7:0] expv);
      checked++;
      if (seen !== expv) begin
         failures++;
         $display("[ERR] %s expected %h seen %h", n, expv, seen);
      end
   endtask : chk

   function automatic logic [7:0] exp_rd(input logic [7:0] a);
      case (a)
         8'h30: return en0 | 8'hC0;
         8'h31: return en1;
         8'h40, 8'h43: return st0;
         8'h41, 8'h44: return st1;
         8'h42: return lp;
         default: return 8'h00;
      endcase
   endfunction : exp_rd

   function automatic void fire(input logic [5:0] e);
      st0 |= {3'h0, e[5], e[4], 2'h0, e[3]};
      st1 |= {3'h0, e[2:0], 2'h0};
      lp  |= {3'h0, e[5] & en0[4], e[4] & en0[3], 3'h0};
   endfunction : fire

   task automatic settle;
      logic a;
      a = |(st0 & en0 & 8'h19) || |(st1 & en1 & 8'h1C);
      repeat (2) @(negedge i_ref_clk);
      chk("alert_n", {7'h0, alert_n}, {7'h0, !a});
   endtask : settle

   task automatic pulse(input logic [5:0] e);
      @(negedge i_ref_clk);
      ev = e;
      @(negedge i_ref_clk);
      ev = '0;
      fire(e);
      settle();
   endtask : pulse

   task automatic rdc(input logic [7:0] a);
      i_hia_host_model.xfer(1'b0, a, 8'h00, d, v);
      chk("rvalid", {7'h0, v}, 8'h01);
      chk("rdata", d, exp_rd(a));
      if (a == 8'h43)
         st0 &= lp & 8'h18;
      if (a == 8'h44)
         st1 = 8'h00;
      settle();
   endtask : rdc

   task automatic wrc(input logic [7:0] a, input logic [7:0] wd);
      i_hia_host_model.xfer(1'b1, a, wd, d, v);
      chk("wr rvalid", {7'h0, v}, 8'h00);
      case (a)
         8'h30: en0 = wd;
         8'h31: en1 = wd;
         8'h42: lp &= wd;
         default: ;
      endcase
      settle();
   endtask : wrc

   // Event pulse lands on the same edge as the clearing read
   task automatic race(input logic [7:0] a, input logic [5:0] e);
      fork
         i_hia_host_model.xfer(1'b0, a, 8'h00, d, v);
         begin
            @(negedge i_ref_clk);
            ev = e;
            @(negedge i_ref_clk);
            ev = '0;
         end
      join
   endtask : race
   ////////////////////////////////////////////////////////////////////
   always @(posedge i_ref_clk) begin
      cycles++;
      if (cycles == 8000) begin
         failures++;
         tally_and_finish();
      end
   end

   initial begin
      void'($urandom(34));
      {st0, st1, lp, en0, en1} = {8'h00, 8'h04, 8'h00, 8'hF7, 8'hFF};
      repeat (20) @(negedge i_ref_clk);
      i_rst = 1'b0;
      foreach (addrs[i]) rdc(addrs[i]);
      // Enabled pass, then fully masked pass
      for (int k = 0; k < 2; k++) begin
         wrc(8'h30, k ? 8'h00 : 8'hFF);
         wrc(8'h31, k ? 8'h00 : 8'hFF);
         for (int i = 0; i < 6; i++) begin
            pulse(6'h01 << i);
            rdc(8'h40);
            rdc(8'h43);
            rdc(8'h41);
            rdc(8'h44);
            wrc(8'h42, 8'h00);
            rdc(8'h43);
         end
      end
      // Event lands on the same edge as the clearing read
      wrc(8'h30, 8'hFF);
      pulse(6'h08);
      race(8'h43, 6'h08);
      chk("race rdata", d, 8'h01);
      settle();
      rdc(8'h40);
      pulse(6'h01);
      race(8'h44, 6'h01);
      chk("race1 rdata", d, 8'h04);
      settle();
      rdc(8'h41);
      repeat (80) begin
         case ($urandom % 3)
            0: pulse(6'($urandom));
            1: wrc(addrs[$urandom % 8], 8'($urandom));
            default: rdc(addrs[$urandom % 8]);
         endcase
      end
      tally_and_finish();
   end
endmodule : hia_top_tb
